//--- logic/supply_supervisor_watchdog.sv
/*
 supply supervisor with reset stretch, watchdog and power-fail passthrough.
 assumes the low-supply comparator drives srst-independent flag supply_low,
 and the kick float detector and power-fail comparator arrive as flags.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - reset output held low for a 200 ms pulse once triggered.
// - reset triggers only from power-up (srst), low supply or manual request low.
// - reset held continuously while low supply flag stays active.
// - release 200 ms after the last of low supply or manual request ends.
// - watchdog expiry never asserts reset internally.
// - active-high reset is always the complement of active-low reset.
// - manual request low generates reset; switch or logic may drive it.
// - manual request debounced so bounce gives one reset event.
// - debounce is the stretch itself; bounces restart the same pulse.
// - floating manual request reads as high, no reset.
// - power-fail output low while sense is below reference, else high.
// - alarm low once kick stays steady longer than the timeout.
// - watchdog timeout is 1.60 s; processor must kick faster.
// - every kick edge clears the watchdog counter and restarts it.
// - watchdog counter held cleared while reset is asserted.
// - watchdog counting starts only after reset deasserts.
// - watchdog disabled entirely while kick input floats.
// - alarm stays low after expiry until counter next cleared.
// - alarm forced low while low supply is active.
// - alarm returns high when low supply clears unless expiry pending.
module supply_supervisor_watchdog #(
   parameter int unsigned STRETCH_CYCLES = supervisor_pkg::STRETCH_CYCLES,
   parameter int unsigned DOG_CYCLES     = supervisor_pkg::DOG_CYCLES
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic supply_low,
   input  wire logic manual_reset_request_n,
   input  wire logic kick_input,
   input  wire logic kick_float,
   input  wire logic supply_sense_low,
   output var  logic cpu_reset_n,
   output var  logic cpu_reset,
   output var  logic dog_alarm_n,
   output var  logic supply_fail_n
);

   localparam int unsigned DW = $clog2(DOG_CYCLES + 1);

   if (DOG_CYCLES < 2) begin : g_dog_check
      $error("supply_supervisor_watchdog: DOG_CYCLES too small");
   end

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   supervisor_pkg::pins_s pins_raw;
   supervisor_pkg::pins_s pins;

   assign pins_raw = '{manual_reset_request_n: manual_reset_request_n,
                       kick_input:             kick_input,
                       kick_float:             kick_float,
                       supply_sense_low:       supply_sense_low};

   // a pull-up on the pad turns a floating request into a high level
   pin_sync #(.INIT(supervisor_pkg::IN_IDLE)) u_sync_mr (
      .clk   (clk),
      .srst  (srst),
      .ce    (ce),
      .pin   (pins_raw.manual_reset_request_n),
      .level (pins.manual_reset_request_n)
   );

   pin_sync #(.INIT(supervisor_pkg::KICK_IDLE)) u_sync_kick (
      .clk   (clk),
      .srst  (srst),
      .ce    (ce),
      .pin   (pins_raw.kick_input),
      .level (pins.kick_input)
   );

   pin_sync #(.INIT(supervisor_pkg::FLOAT_IDLE)) u_sync_float (
      .clk   (clk),
      .srst  (srst),
      .ce    (ce),
      .pin   (pins_raw.kick_float),
      .level (pins.kick_float)
   );

   pin_sync #(.INIT(supervisor_pkg::SENSE_IDLE)) u_sync_pf (
      .clk   (clk),
      .srst  (srst),
      .ce    (ce),
      .pin   (pins_raw.supply_sense_low),
      .level (pins.supply_sense_low)
   );

   // ----------------------------------------
   // reset stretch
   // ----------------------------------------
   logic reset_hold;
   logic stretch_busy;

   // only these two sources; the alarm is not one of them
   // low supply reaches the timer through hold alone, which reloads it
   assign reset_hold = supply_low | ~pins.manual_reset_request_n;

   // every bounce reloads the full count, so one clean pulse results
   stretch_timer #(.CYCLES(STRETCH_CYCLES)) u_stretch (
      .clk   (clk),
      .srst  (srst),
      .ce    (ce),
      .hold  (reset_hold),
      .busy  (stretch_busy)
   );

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      supervisor_pkg::outs_s outs;
      logic                  kick_last;
      logic [DW-1:0]         dog_count;
      logic                  expired;
   } state_s;

   state_s st_ff;
   state_s nxt_st;

   function automatic logic in_reset(input logic hold, input logic busy);
      in_reset = hold | busy;
   endfunction : in_reset

   always_comb begin
      nxt_st = st_ff;
      nxt_st.kick_last = pins.kick_input;

      // low for 200 ms per trigger, and while a source stays active
      nxt_st.outs.cpu_reset_n = ~in_reset(reset_hold, stretch_busy);
      nxt_st.outs.cpu_reset   = in_reset(reset_hold, stretch_busy);

      // registered inverse of the synchronised sense flag, no tie to reset or watchdog
      nxt_st.outs.supply_fail_n = ~pins.supply_sense_low;

      if (in_reset(reset_hold, stretch_busy) || !st_ff.outs.cpu_reset_n) begin
         // cleared in reset; count begins once reset is high
         nxt_st.dog_count = '0;
         nxt_st.expired   = 1'b0;
      end else if (pins.kick_float) begin
         nxt_st.dog_count = '0;
         nxt_st.expired   = 1'b0;
      end else if (pins.kick_input != st_ff.kick_last) begin
         nxt_st.dog_count = '0;
         nxt_st.expired   = 1'b0;
      end else if (st_ff.dog_count >= DW'(DOG_CYCLES)) begin
         nxt_st.expired = 1'b1;
      end else begin
         nxt_st.dog_count = st_ff.dog_count + DW'(1);
      end

      // low supply overrides; released once it clears unless expired
      nxt_st.outs.dog_alarm_n = ~(supply_low | nxt_st.expired);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff.outs.cpu_reset_n   <= supervisor_pkg::RST_N_INIT;
         st_ff.outs.cpu_reset     <= ~supervisor_pkg::RST_N_INIT;
         st_ff.outs.dog_alarm_n   <= ~supervisor_pkg::ALARM_N_INIT;
         st_ff.outs.supply_fail_n <= supervisor_pkg::FAIL_N_INIT;
         st_ff.kick_last          <= supervisor_pkg::KICK_IDLE;
         st_ff.dog_count          <= '0;
         st_ff.expired            <= 1'b0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign cpu_reset_n   = st_ff.outs.cpu_reset_n;
   assign cpu_reset     = st_ff.outs.cpu_reset;
   assign dog_alarm_n   = st_ff.outs.dog_alarm_n;
   assign supply_fail_n = st_ff.outs.supply_fail_n;

endmodule : supply_supervisor_watchdog

`default_nettype wire

//--- logic/supervisor_pkg.sv
/*
 package for the supply supervisor: timing constants, reset values and the
 packed structs that carry the flags and the outputs.
 assumes a single 20 mhz clock; all analog results arrive as digital flags.
*/
`default_nettype none

package supervisor_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned STRETCH_MS      = 200;
   localparam int unsigned DOG_TIMEOUT_MS  = 1600;
   localparam int unsigned STRETCH_CYCLES  = (CLK_HZ / 1000) * STRETCH_MS;
   localparam int unsigned DOG_CYCLES      = (CLK_HZ / 1000) * DOG_TIMEOUT_MS;
   localparam int unsigned SYNC_STAGES     = 3;

   // ----------------------------------------
   // reset values of the outputs (alarm loads the complement of ALARM_N_INIT) and input idle levels
   // ----------------------------------------
   localparam logic RST_N_INIT      = 1'b0;
   localparam logic ALARM_N_INIT    = 1'b1;
   localparam logic FAIL_N_INIT     = 1'b1;
   localparam logic IN_IDLE         = 1'b1;
   localparam logic KICK_IDLE       = 1'b0;
   localparam logic FLOAT_IDLE      = 1'b1;
   localparam logic SENSE_IDLE      = 1'b0;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic manual_reset_request_n;
      logic kick_input;
      logic kick_float;
      logic supply_sense_low;
   } pins_s;

   typedef struct packed {
      logic cpu_reset_n;
      logic cpu_reset;
      logic dog_alarm_n;
      logic supply_fail_n;
   } outs_s;

endpackage : supervisor_pkg

`default_nettype wire

//--- logic/pin_sync.sv
/*
 three-stage synchroniser with agreement filter for one pin.
 assumes the pin is asynchronous to clk; output changes once stages two and
 three agree.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter logic INIT = 1'b1
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic pin,
   output var  logic level
);

   typedef struct packed {
      logic [2:0] stage;
      logic       level;
   } sync_s;

   sync_s st_ff;
   sync_s nxt_st;

   // ----------------------------------------
   // filter
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.stage = {st_ff.stage[1:0], pin};
      // stage 0 only feeds stage 1
      if (st_ff.stage[1] == st_ff.stage[2]) begin
         nxt_st.level = st_ff.stage[2];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= {{3{INIT}}, INIT};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.level;

endmodule : pin_sync

`default_nettype wire

//--- logic/stretch_timer.sv
/*
 down counter that restarts while its hold input is high and reports done
 once the full count has elapsed after hold falls.
 assumes hold comes from clk-domain logic.
*/
`timescale 1ns/1ps
`default_nettype none

module stretch_timer #(
   parameter int unsigned CYCLES = 4000000
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic ce,
   input  wire logic hold,
   output var  logic busy
);

   localparam int unsigned W = $clog2(CYCLES + 1);

   // a count below two leaves no room for the busy flag to drop
   if (CYCLES < 2) begin : g_cycles_check
      $error("stretch_timer: CYCLES too small");
   end

   typedef struct packed {
      logic [W-1:0] count;
      logic         busy;
   } tmr_s;

   tmr_s st_ff;
   tmr_s nxt_st;

   // ----------------------------------------
   // count
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (hold) begin
         nxt_st.count = W'(CYCLES);
         nxt_st.busy  = 1'b1;
      end else if (st_ff.count != '0) begin
         nxt_st.count = st_ff.count - W'(1);
         nxt_st.busy  = (st_ff.count != W'(1));
      end else begin
         nxt_st.busy = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         // power-up counts as a fresh trigger
         st_ff <= {W'(CYCLES), 1'b1};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign busy = st_ff.busy;

endmodule : stretch_timer

`default_nettype wire

//--- testbench/supervisor_monitor.sv
/* port assertions for the supervisor.
   assumes a bind from the bench top; checks pause while ce is low. */
`timescale 1ns/1ps
`default_nettype none
module supervisor_monitor #(
   parameter int unsigned STRETCH_CYCLES = 20,
   parameter int unsigned DOG_CYCLES     = 50
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic supply_low,
   input wire logic manual_reset_request_n,
   input wire logic kick_input,
   input wire logic kick_float,
   input wire logic supply_sense_low,
   input wire logic cpu_reset_n,
   input wire logic cpu_reset,
   input wire logic dog_alarm_n,
   input wire logic supply_fail_n
);
   int unsigned low_cnt;
   int unsigned quiet_cnt;
   int unsigned steady_cnt;
   int unsigned clr_cnt;
   logic        kick_q;
   // ----------------------------------------
   // counters on raw pins: they lead the synchronisers, so they are upper bounds
   // ----------------------------------------
   always_ff @(posedge clk) begin
      kick_q     <= kick_input;
      low_cnt    <= (srst || cpu_reset_n) ? 0 : low_cnt + 1;
      quiet_cnt  <= (srst || !manual_reset_request_n || supply_low) ? 0 : quiet_cnt + 1;
      steady_cnt <= (srst || kick_input != kick_q || !cpu_reset_n || kick_float) ? 0
                    : steady_cnt + 1;
      clr_cnt    <= (srst || kick_input != kick_q || !cpu_reset_n || kick_float || supply_low
                     || !manual_reset_request_n) ? 0 : clr_cnt + 1;
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (srst || !ce);
   cmpl_reset_a: assert property (cpu_reset == !cpu_reset_n)
      else $error("reset outputs not complementary");
   low_supply_reset_a: assert property (supply_low |=> !cpu_reset_n)
      else $error("low supply without reset");
   manual_reset_a: assert property (!manual_reset_request_n [*4] |-> ##[0:4] !cpu_reset_n)
      else $error("manual request without reset");
   stretch_rel_a: assert property ($rose(cpu_reset_n) |->
      low_cnt >= STRETCH_CYCLES && quiet_cnt >= STRETCH_CYCLES)
      else $error("reset released early");
   no_dog_reset_a: assert property ($fell(cpu_reset_n) |-> quiet_cnt < 8)
      else $error("reset without a source");
   fail_track_a: assert property ($stable(supply_sense_low) [*6] |->
      supply_fail_n == !supply_sense_low)
      else $error("power-fail output wrong");
   dog_expiry_a: assert property (
      $fell(dog_alarm_n) && !supply_low && !$past(supply_low) |-> steady_cnt >= DOG_CYCLES)
      else $error("alarm before timeout");
   float_off_a: assert property ((kick_float && !supply_low) [*8] |-> dog_alarm_n)
      else $error("alarm while kick floats");
   supply_alarm_a: assert property (supply_low |=> !dog_alarm_n)
      else $error("alarm not forced low");
   alarm_hold_a: assert property ($rose(dog_alarm_n) |-> clr_cnt < 8)
      else $error("alarm rose without a clear");
   cover property ($fell(dog_alarm_n));
   cover property ($rose(cpu_reset_n));
   cover property ($fell(supply_fail_n));
endmodule : supervisor_monitor
`default_nettype wire

//--- testbench/cpu_model.sv
/* processor model: kicks the watchdog, can stall or float the kick pin.
   assumes inputs from the bench clock domain. */
`timescale 1ns/1ps
`default_nettype none
module cpu_model #(
   parameter int PERIOD = 12
) (
   input  wire logic clk,
   input  wire logic cpu_reset_n,
   input  wire logic run,
   input  wire logic flt,
   output var  logic kick_input,
   output var  logic kick_float
);
   int cnt = 0;
   initial kick_input = 1'b0;
   always @(posedge clk) begin
      cnt        <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      kick_float <= flt;
      if (flt) begin
         kick_input <= ~kick_input; // released pin shows a pattern, not its last level
      end else if (run && cpu_reset_n && cnt == 0) begin
         kick_input <= ~kick_input;
      end
   end
endmodule : cpu_model
`default_nettype wire

//--- testbench/supply_supervisor_watchdog_tb.sv
/* self-checking bench for the supervisor with shortened counts.
   assumes cpu_model and supervisor_monitor compiled first. */
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
   localparam int S = 20;
   localparam int D = 50;
   logic clk        = 1'b0;
   logic srst       = 1'b1;
   logic mr_n       = 1'b1; // idles at pull-up level
   logic supply_low = 1'b0;
   logic sense_low  = 1'b0;
   logic run        = 1'b1;
   logic flt        = 1'b0;
   logic ce         = 1'b1;
   logic kick, kick_flt, rst_n, rst, alarm_n, fail_n;
   int   n_errors   = 0;
   int   n_tests    = 0;
   int   n, k;
   logic exp_q[$];
   always #25 clk = ~clk;
   supply_supervisor_watchdog #(.STRETCH_CYCLES(S), .DOG_CYCLES(D)) uut (
      .clk(clk), .srst(srst), .ce(ce), .supply_low(supply_low),
      .manual_reset_request_n(mr_n), .kick_input(kick), .kick_float(kick_flt),
      .supply_sense_low(sense_low), .cpu_reset_n(rst_n), .cpu_reset(rst),
      .dog_alarm_n(alarm_n), .supply_fail_n(fail_n));
   cpu_model cpu (.clk(clk), .cpu_reset_n(rst_n), .run(run), .flt(flt),
      .kick_input(kick), .kick_float(kick_flt));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   task automatic span(input string what, input int v, input int lo, input int hi);
      check(what, 32'(v >= lo && v <= hi), 32'h1);
   endtask : span
   // bounded wait on reset or alarm; counts falling edges
   task automatic wait_out(input logic dog, input logic v, input int lim, output int cnt);
      cnt = 0;
      while ((dog ? alarm_n : rst_n) !== v && cnt < lim) begin
         @(negedge clk);
         cnt++;
      end
      if ((dog ? alarm_n : rst_n) !== v) begin
         n_errors++;
         $display("CHECK FAILED wait expected %0h seen timeout", v);
         print_verdict();
      end
   endtask : wait_out
   initial begin
      void'($urandom(32'h23df));
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      check("reset_n at release", rst_n, 1'b0);
      check("reset complement", rst, 1'b1);
      wait_out(1'b0, 1'b1, S + 20, n);
      span("power-on stretch", n, S - 1, S + 6);
      $display("test power-on done");
      @(posedge clk) mr_n <= 1'b0;
      wait_out(1'b0, 1'b0, 10, n);
      span("manual latency", n, 1, 8);
      for (int i = 0; i < 12; i++) begin
         @(posedge clk) mr_n <= 1'($urandom_range(0, 1));
         @(negedge clk) check("held in bounce", rst_n, 1'b0);
      end
      @(posedge clk) mr_n <= 1'b0;
      repeat (3) @(posedge clk);
      mr_n <= 1'b1;
      wait_out(1'b0, 1'b1, S + 20, n);
      span("manual stretch", n, S, S + 10);
      repeat (2 * S) @(negedge clk);
      check("single reset event", rst_n, 1'b1);
      $display("test manual reset done");
      k = $urandom_range(30, 60);
      @(posedge clk) supply_low <= 1'b1;
      repeat (2) @(negedge clk);
      check("alarm forced", alarm_n, 1'b0);
      n = 0;
      repeat (k) begin
         @(negedge clk);
         n += (rst_n === 1'b0);
      end
      check("reset over brown-out", n, k);
      @(posedge clk) supply_low <= 1'b0;
      repeat (3) @(negedge clk);
      check("alarm back high", alarm_n, 1'b1);
      wait_out(1'b0, 1'b1, S + 20, n);
      span("supply stretch", n, S - 3, S + 8);
      $display("test brown-out done");
      repeat (3 * D) @(negedge clk);
      check("alarm while kicked", alarm_n, 1'b1);
      @(posedge clk) run <= 1'b0;
      wait_out(1'b1, 1'b0, D + 20, n);
      span("expiry time", n, D - 13, D + 10);
      repeat (20) @(negedge clk);
      check("alarm holds", alarm_n, 1'b0);
      check("no reset on expiry", rst_n, 1'b1);
      @(posedge clk) run <= 1'b1;
      wait_out(1'b1, 1'b1, 25, n);
      span("kick clears", n, 1, 20);
      @(posedge clk) begin
         run  <= 1'b0;
         mr_n <= 1'b0;
      end
      repeat (2 * D) @(posedge clk);
      mr_n <= 1'b1;
      wait_out(1'b1, 1'b0, S + D + 30, n);
      span("timeout from release", n, S + D - 2, S + D + 14);
      $display("test watchdog done");
      @(posedge clk) flt <= 1'b1;
      repeat (3 * D) @(negedge clk);
      check("float disables", alarm_n, 1'b1);
      @(posedge clk) flt <= 1'b0;
      $display("test float done");
      for (int i = 0; i < 10; i++) begin
         k = $urandom_range(0, 1);
         @(posedge clk) sense_low <= k[0];
         exp_q.push_back(!k[0]);
         repeat (6) @(negedge clk);
         check("power-fail", fail_n, exp_q.pop_front());
      end
      $display("test power-fail done");
      // a frozen block must hold its outputs while the pin moves
      @(posedge clk) ce <= 1'b0;
      @(negedge clk) k = fail_n;
      @(posedge clk) sense_low <= ~sense_low;
      repeat (10) @(negedge clk);
      check("frozen power-fail", fail_n, k[0]);
      @(posedge clk) ce <= 1'b1;
      repeat (6) @(negedge clk);
      check("thawed power-fail", fail_n, !sense_low);
      $display("test clock enable done");
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("CHECK FAILED run expected end seen timeout");
      print_verdict();
   end
endmodule : supply_supervisor_watchdog_tb
bind supply_supervisor_watchdog supervisor_monitor #(
   .STRETCH_CYCLES(STRETCH_CYCLES), .DOG_CYCLES(DOG_CYCLES)) mon (
   .clk(clk), .srst(srst), .ce(ce), .supply_low(supply_low),
   .manual_reset_request_n(manual_reset_request_n), .kick_input(kick_input),
   .kick_float(kick_float), .supply_sense_low(supply_sense_low),
   .cpu_reset_n(cpu_reset_n), .cpu_reset(cpu_reset), .dog_alarm_n(dog_alarm_n),
   .supply_fail_n(supply_fail_n));
`default_nettype wire
